// >>> bench/test_pc_write_and_status_transfer.sv
// self-checking bench for the pc write and status transfer core
// assumes pws_core holds its own saved-word banks and takes one instruction per ready edge
`timescale 1ns/100ps
`default_nettype none
module test_pc_write_and_status_transfer;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic issue_valid = 1'b0;
	logic [31:0] issue_word = 32'h0000_0000;
	logic [31:0] issue_addr = 32'h0000_0000;
	logic [31:0] op_rm = 32'h0000_0000;
	logic [31:0] alu_result = 32'h0000_0000;
	logic alu_carry = 1'b0;
	logic alu_overflow = 1'b0;
	logic shift_carry = 1'b0;
	logic issue_ready_ff, pc_write_ff, reg_write_ff;
	logic [31:0] pc_operand_ff, pc_value_ff, reg_data_ff, current_status_word_ff;
	logic [31:0] saved_status_word_ff;
	logic [3:0] reg_index_ff;
	logic [1:0] cyc_s_ff, cyc_n_ff, cyc_i_ff;
	int num_errors = 0;
	int check_count = 0;

	pws_core i_dut (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
		.issue_word(issue_word), .issue_addr(issue_addr), .op_rm(op_rm),
		.alu_result(alu_result), .alu_carry(alu_carry), .alu_overflow(alu_overflow),
		.shift_carry(shift_carry), .issue_ready_ff(issue_ready_ff),
		.pc_operand_ff(pc_operand_ff), .pc_write_ff(pc_write_ff), .pc_value_ff(pc_value_ff),
		.reg_write_ff(reg_write_ff), .reg_index_ff(reg_index_ff), .reg_data_ff(reg_data_ff),
		.current_status_word_ff(current_status_word_ff),
		.saved_status_word_ff(saved_status_word_ff),
		.cyc_s_ff(cyc_s_ff), .cyc_n_ff(cyc_n_ff), .cyc_i_ff(cyc_i_ff));

	always #4 clk = ~clk;

	// =====================================================================
	// helpers
	function automatic logic [31:0] enc(input logic i, input logic [3:0] op, input logic s,
		input logic [3:0] rn, input logic [3:0] rd, input logic [11:0] op2);
		enc = {4'he, 2'b00, i, op, s, rn, rd, op2};
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// offers one instruction at a falling edge and returns half a cycle after it is taken, at the next falling edge;
	// valid is left up so a following call issues back to back
	task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] rm,
		input logic [31:0] res, input logic c, input logic v, input logic sc);
		int n;
		n = 0;
		while (issue_ready_ff !== 1'b1 && n < 10) begin
			n++;
			@(negedge clk);
		end
		if (n == 10) chk("issue ready", {31'h0, issue_ready_ff}, 32'h0000_0001);
		issue_valid = 1'b1;
		issue_word = w;
		issue_addr = a;
		op_rm = rm;
		alu_result = res;
		alu_carry = c;
		alu_overflow = v;
		shift_carry = sc;
		@(negedge clk);
	endtask

	// drops valid and counts the cycles for which ready stays low; n < 0 skips the check of the count
	task automatic settle(input int n);
		int k;
		issue_valid = 1'b0;
		k = 0;
		while (issue_ready_ff !== 1'b1 && k < 10) begin
			k++;
			@(negedge clk);
		end
		if (n >= 0) chk("ready low cycles", 32'(k), 32'(n));
		// one idle edge so the next issue never raises valid in the step that dropped it
		@(negedge clk);
	endtask

	task automatic cycles(input logic [1:0] s, input logic [1:0] n, input logic [1:0] i);
		chk("s cycles", {30'h0, cyc_s_ff}, {30'h0, s});
		chk("n cycles", {30'h0, cyc_n_ff}, {30'h0, n});
		chk("i cycles", {30'h0, cyc_i_ff}, {30'h0, i});
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// =====================================================================
	// tests
	initial begin
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		chk("reset status", current_status_word_ff, 32'h0000_00d3);
		chk("reset saved", saved_status_word_ff, 32'h0000_0000);
		chk("reset ready", {31'h0, issue_ready_ff}, 32'h0000_0001);
		$display("test reset done");

		issue(enc(1'b1, 4'h9, 1'b0, 4'h8, 4'hf, 12'h4f0), 32'h0000_0000, 32'h0000_0000,
			32'h0000_0000, 1'b0, 1'b0, 1'b0);
		chk("flags write", current_status_word_ff, 32'hf000_00d3);
		chk("transfer ready", {31'h0, issue_ready_ff}, 32'h0000_0001);
		cycles(2'h1, 2'h0, 2'h0);
		issue(enc(1'b0, 4'hb, 1'b0, 4'h9, 4'hf, 12'h000), 32'h0, 32'h1234_5610, 32'h0, 0, 0, 0);
		chk("saved write svc", saved_status_word_ff, 32'h1234_5610);
		issue(enc(1'b0, 4'ha, 1'b0, 4'hf, 4'h4, 12'h000), 32'h0, 32'h0, 32'h0, 0, 0, 0);
		chk("read saved data", reg_data_ff, 32'h1234_5610);
		chk("read saved wr", {31'h0, reg_write_ff}, 32'h0000_0001);
		chk("read saved idx", {28'h0, reg_index_ff}, 32'h0000_0004);
		settle(0);
		$display("test transfers done");

		issue(enc(1'b0, 4'h9, 1'b0, 4'h9, 4'hf, 12'h000),
			32'h0, 32'h0000_0012, 32'h0, 0, 0, 0);
		chk("whole write priv", current_status_word_ff, 32'h0000_0012);
		chk("irq bank empty", saved_status_word_ff, 32'h0000_0000);
		issue(enc(1'b0, 4'h8, 1'b0, 4'hf, 4'h5, 12'h000), 32'h0, 32'h0, 32'h0, 0, 0, 0);
		chk("read back status", reg_data_ff, 32'h0000_0012);
		issue(enc(1'b0, 4'hb, 1'b0, 4'h9, 4'hf, 12'h000), 32'h0, 32'h8000_0013, 32'h0, 0, 0, 0);
		chk("saved write irq", saved_status_word_ff, 32'h8000_0013);
		issue(enc(1'b1, 4'hb, 1'b0, 4'h8, 4'hf, 12'h4c0), 32'h0, 32'h0, 32'h0, 0, 0, 0);
		chk("saved flags irq", saved_status_word_ff, 32'hc000_0013);
		settle(0);
		$display("test banks done");

		issue(enc(1'b1, 4'hd, 1'b1, 4'h0, 4'hf, 12'h000), 32'h100, 32'h0, 32'h1000, 0, 0, 0);
		chk("restore pc", {31'h0, pc_write_ff}, 32'h0000_0001);
		chk("restore value", pc_value_ff, 32'h0000_1000);
		chk("restore status", current_status_word_ff, 32'hc000_0013);
		chk("svc bank back", saved_status_word_ff, 32'h1234_5610);
		cycles(2'h2, 2'h1, 2'h0);
		settle(2);
		issue(enc(1'b0, 4'hd, 1'b0, 4'h0, 4'hf, 12'h210), 32'h200, 32'h0, 32'h2000, 1, 1, 1);
		chk("plain pc write", pc_value_ff, 32'h0000_2000);
		chk("status kept", current_status_word_ff, 32'hc000_0013);
		chk("pc plus 12", pc_operand_ff, 32'h0000_020c);
		cycles(2'h2, 2'h1, 2'h1);
		settle(3);
		$display("test pc writes done");

		issue(enc(1'b1, 4'h4, 1'b1, 4'h1, 4'h3, 12'h001), 32'h300, 32'h0, 32'h0, 1, 0, 0);
		chk("arith flags", current_status_word_ff, 32'h6000_0013);
		chk("add reg write", {31'h0, reg_write_ff}, 32'h0000_0001);
		chk("add no pc", {31'h0, pc_write_ff}, 32'h0000_0000);
		chk("pc plus 8", pc_operand_ff, 32'h0000_0308);
		cycles(2'h1, 2'h0, 2'h0);
		// multiply space shares the class bits: no flag, register write, pc operand or cycle count of this block may move
		issue(enc(1'b0, 4'h0, 1'b1, 4'h1, 4'h2, 12'h093), 32'h400, 32'h0, 32'h8000_0000,
			0, 0, 0);
		chk("mul no flags", current_status_word_ff, 32'h6000_0013);
		chk("mul no reg", {31'h0, reg_write_ff}, 32'h0000_0000);
		chk("mul pc kept", pc_operand_ff, 32'h0000_0308);
		cycles(2'h1, 2'h0, 2'h0);
		// shifter carry low, alu carry high: logical ops must take the shifter's
		for (int op = 8; op < 12; op++) begin
			issue(enc(1'b0, 4'(op), 1'b1, 4'h1, 4'h0, 12'h000), 32'h0, 32'h0, 32'h8000_0000,
				1, 1, 0);
			chk("test op flags", current_status_word_ff,
				{2'b10, (op >= 10), (op >= 10), 28'h000_0013});
			chk("test op no reg", {31'h0, reg_write_ff}, 32'h0000_0000);
		end
		settle(0);
		$display("test flag ops done");

		issue(enc(1'b0, 4'h9, 1'b0, 4'h9, 4'hf, 12'h000),
			32'h0, 32'h0000_0010, 32'h0, 0, 0, 0);
		chk("user no saved", saved_status_word_ff, 32'h0000_0000);
		issue(enc(1'b0, 4'h9, 1'b0, 4'h9, 4'hf, 12'h000),
			32'h0, 32'h5000_001f, 32'h0, 0, 0, 0);
		chk("user protect", current_status_word_ff, 32'h5000_0010);
		issue(enc(1'b1, 4'h9, 1'b1, 4'h0, 4'hf, 12'h000),
			32'h0, 32'h0, 32'h3000, 0, 0, 0);
		chk("legacy user", current_status_word_ff, 32'h5000_0010);
		chk("legacy no pc", {31'h0, pc_write_ff}, 32'h0000_0000);
		settle(0);
		$display("test user mode done");
		report_and_stop();
	end

	// the whole sequence needs well under 200 cycles
	initial begin
		#8000;
		num_errors++;
		report_and_stop();
	end
endmodule // test_pc_write_and_status_transfer
`default_nettype wire

// >>> design/pws_bank_if.sv
// carrier between the core logic and the banked saved-word memory
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface pws_bank_if;
	logic wr_en;
	logic [pws_pkg::PWS_BANK_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [pws_pkg::PWS_BANK_AW-1:0] rd_addr;
	logic [31:0] rd_data;
	modport core(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> design/pws_core.sv
// pc write, pc operand and status word transfer logic of the execute stage
// assumes issue inputs come from logic on the same clock and the condition has passed
// Operation
// - non-pc destination with S updates flags
// - pc destination without S: write pc only
// - pc destination with S: also restore saved word in a mode with a saved bank
// - immediate shift: pc operand is address+8
// - register shift: pc operand is address+12
// - test and compare ops write flags only
// - legacy test-restore: modes with a saved bank restore, user and unbanked modes ignore
// - cycle costs: 1S, +1I, 2S+1N, 2S+1N+1I
// - test/compare encodings without S are transfers
// - status read moves the whole 32-bit word; writes follow the rules below
// - flags-only write loads top four bits
// - user mode protects control bits
// - privileged whole write replaces all bits
// - saved word bank follows current mode
// - eleven defined bits, others reserved
// - every transfer takes one S cycle
// - negative from bit 31, zero only on zero
`timescale 1ns/100ps
`default_nettype none
module pws_core (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic issue_valid,
	input wire logic [31:0] issue_word,
	input wire logic [31:0] issue_addr,
	input wire logic [31:0] op_rm,
	input wire logic [31:0] alu_result,
	input wire logic alu_carry,
	input wire logic alu_overflow,
	input wire logic shift_carry,
	output logic issue_ready_ff,
	output logic [31:0] pc_operand_ff,
	output logic pc_write_ff,
	output logic [31:0] pc_value_ff,
	output logic reg_write_ff,
	output logic [3:0] reg_index_ff,
	output logic [31:0] reg_data_ff,
	output logic [31:0] current_status_word_ff,
	output logic [31:0] saved_status_word_ff,
	output logic [1:0] cyc_s_ff,
	output logic [1:0] cyc_n_ff,
	output logic [1:0] cyc_i_ff
);
	pws_bank_if bif();
	pws_pkg::pws_state_t state_ff;
	logic [1:0] cnt_ff;
	logic accept, dp_op, is_test, psr_op, psr_write, psr_saved, psr_whole;
	logic imm_op, set_f, rd_pc, reg_shift, pc_wr, restore, flag_upd, arith, priv, has_bank;
	logic [3:0] opcode, rd_idx;
	logic [31:0] src, saved, nxt_cur, bank_wdata;
	logic bank_we;
	logic [1:0] nxt_s, nxt_n, nxt_i, extra;

	pws_saved_bank u_bank (
		.clk(clk),
		.rst_b(rst_b),
		.bif(bif.mem)
	);

	// =====================================================================
	// decode
	assign accept = issue_valid && issue_ready_ff;
	assign opcode = issue_word[pws_pkg::PWS_OP_LO +: 4];
	assign rd_idx = issue_word[pws_pkg::PWS_RD_LO +: 4];
	assign imm_op = issue_word[pws_pkg::PWS_B_IMM];
	assign set_f = issue_word[pws_pkg::PWS_B_SETF];
	// multiply space shares the class bits; it is left to its own unit
	assign dp_op = (issue_word[pws_pkg::PWS_CLASS_LO +: 2] == pws_pkg::PWS_CLASS_DP)
		&& (imm_op || !(issue_word[pws_pkg::PWS_B_MULT] && issue_word[pws_pkg::PWS_B_REGSHIFT]));
	assign is_test = (opcode[3:2] == pws_pkg::PWS_OP_TESTS);
	assign psr_op = dp_op && is_test && !set_f;
	assign psr_write = issue_word[pws_pkg::PWS_B_PSR_WRITE];
	assign psr_saved = issue_word[pws_pkg::PWS_B_PSR_SAVED];
	assign psr_whole = issue_word[pws_pkg::PWS_B_PSR_WHOLE];
	assign reg_shift = dp_op && !imm_op && issue_word[pws_pkg::PWS_B_REGSHIFT] && !psr_op;
	assign rd_pc = (rd_idx == pws_pkg::PWS_PC_REG);
	assign pc_wr = dp_op && !psr_op && !is_test && rd_pc;
	assign restore = dp_op && !psr_op && set_f && rd_pc;
	assign flag_upd = dp_op && !psr_op && set_f && !rd_pc;
	assign arith = (opcode[3:1] == 3'h1) || (opcode[3:2] == 2'h1)
		|| (opcode == pws_pkg::PWS_OP_CMP) || (opcode == pws_pkg::PWS_OP_CMN);
	assign priv = pws_pkg::pws_is_priv(current_status_word_ff[4:0]);
	assign has_bank = (pws_pkg::pws_bank_of(current_status_word_ff[4:0]) != pws_pkg::PWS_BANK_NONE);
	assign saved = bif.rd_data;
	assign saved_status_word_ff = bif.rd_data;
	assign src = imm_op ? pws_pkg::pws_rot_imm(issue_word[7:0], issue_word[pws_pkg::PWS_ROT_LO +: 4])
		: op_rm;

	// =====================================================================
	// next status words; reserved bits are stored as written
	always_comb begin
		nxt_cur = current_status_word_ff;
		bank_we = 1'b0;
		bank_wdata = saved;
		if (accept && psr_op && psr_write) begin
			if (!psr_saved) begin
				if (psr_whole && priv) begin
					nxt_cur = src;
				end else begin
					nxt_cur = {src[31:28], current_status_word_ff[27:0]};
				end
			end else if (has_bank) begin
				bank_we = 1'b1;
				bank_wdata = psr_whole ? src : {src[31:28], saved[27:0]};
			end
		end else if (accept && restore) begin
			if (priv && has_bank) begin
				nxt_cur = saved;
			end
		end else if (accept && flag_upd) begin
			nxt_cur[pws_pkg::PWS_SW_N] = alu_result[31];
			nxt_cur[pws_pkg::PWS_SW_Z] = (alu_result == 32'h0000_0000);
			nxt_cur[pws_pkg::PWS_SW_C] = arith ? alu_carry : shift_carry;
			if (arith) begin
				nxt_cur[pws_pkg::PWS_SW_V] = alu_overflow;
			end
		end
	end

	// the read port tracks the mode of the next word so a new bank is ready at once
	assign bif.rd_addr = pws_pkg::pws_bank_of(nxt_cur[4:0]);
	assign bif.wr_addr = pws_pkg::pws_bank_of(current_status_word_ff[4:0]);
	assign bif.wr_en = bank_we;
	assign bif.wr_data = bank_wdata;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			current_status_word_ff <= pws_pkg::PWS_SW_RESET;
		end else begin
			current_status_word_ff <= nxt_cur;
		end
	end

	// =====================================================================
	// program counter operand and write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_operand_ff <= 32'h0000_0000;
			pc_write_ff <= 1'b0;
			pc_value_ff <= 32'h0000_0000;
		end else begin
			pc_write_ff <= accept && pc_wr;
			if (accept && dp_op) begin
				pc_operand_ff <= issue_addr
					+ (reg_shift ? pws_pkg::PWS_PC_AHEAD_REG : pws_pkg::PWS_PC_AHEAD_IMM);
			end
			if (accept && pc_wr) begin
				pc_value_ff <= alu_result;
			end
		end
	end

	// =====================================================================
	// general register write: status read or ordinary result
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_write_ff <= 1'b0;
			reg_index_ff <= 4'h0;
			reg_data_ff <= 32'h0000_0000;
		end else begin
			reg_write_ff <= accept && ((psr_op && !psr_write) || (dp_op && !psr_op && !is_test && !rd_pc));
			if (accept) begin
				reg_index_ff <= rd_idx;
				reg_data_ff <= (psr_op && !psr_write)
					? (psr_saved ? saved : current_status_word_ff) : alu_result;
			end
		end
	end

	// =====================================================================
	// cycle accounting; the issue port stalls for the extra cycles
	always_comb begin
		nxt_s = pc_wr ? pws_pkg::PWS_CYC_S_PCWR : pws_pkg::PWS_CYC_S_PLAIN;
		nxt_n = pc_wr ? pws_pkg::PWS_CYC_N_PCWR : 2'h0;
		nxt_i = reg_shift ? pws_pkg::PWS_CYC_I_REGSHIFT : 2'h0;
		extra = 2'(nxt_s + nxt_n + nxt_i - 2'h1);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= pws_pkg::PWS_ST_IDLE;
			cnt_ff <= 2'h0;
			issue_ready_ff <= 1'b1;
			cyc_s_ff <= 2'h0;
			cyc_n_ff <= 2'h0;
			cyc_i_ff <= 2'h0;
		end else begin
			case (state_ff)
				pws_pkg::PWS_ST_IDLE: begin
					if (accept) begin
						cyc_s_ff <= nxt_s;
						cyc_n_ff <= nxt_n;
						cyc_i_ff <= nxt_i;
						if (extra != 2'h0) begin
							state_ff <= pws_pkg::PWS_ST_BUSY;
							cnt_ff <= extra;
							issue_ready_ff <= 1'b0;
						end
					end
				end
				pws_pkg::PWS_ST_BUSY: begin
					cnt_ff <= cnt_ff - 2'h1;
					if (cnt_ff == 2'h1) begin
						state_ff <= pws_pkg::PWS_ST_IDLE;
						issue_ready_ff <= 1'b1;
					end
				end
				default: state_ff <= pws_pkg::PWS_ST_IDLE;
			endcase
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	pc_write_a: assert property (accept && pc_wr |=> pc_write_ff && (pc_value_ff == $past(alu_result)))
		else $error("pc write missing or wrong value");
	pc_keep_a: assert property (accept && pc_wr && !set_f |=> $stable(current_status_word_ff))
		else $error("status word changed on plain pc write");
	restore_a: assert property (accept && restore && priv && has_bank
		|=> current_status_word_ff == $past(saved_status_word_ff))
		else $error("saved word not restored");
	legacy_user_a: assert property (accept && restore && !priv |=> $stable(current_status_word_ff))
		else $error("user mode restore changed status");
	flag_zero_a: assert property (accept && flag_upd
		|=> current_status_word_ff[30] == ($past(alu_result) == 32'h0000_0000))
		else $error("zero flag wrong");
	pc_ahead_a: assert property (accept && dp_op && reg_shift
		|=> pc_operand_ff == $past(issue_addr) + 32'h0000_000c)
		else $error("pc operand not twelve ahead");
	pc_imm_a: assert property (accept && dp_op && !reg_shift
		|=> pc_operand_ff == $past(issue_addr) + 32'h0000_0008)
		else $error("pc operand not eight ahead");
	user_protect_a: assert property (accept && psr_op && psr_write && !psr_saved && !priv
		|=> current_status_word_ff[27:0] == $past(current_status_word_ff[27:0]))
		else $error("user mode control bits changed");
	priv_whole_a: assert property (accept && psr_op && psr_write && !psr_saved && psr_whole && priv
		|=> current_status_word_ff == $past(src))
		else $error("privileged whole write lost bits");
	flags_only_a: assert property (accept && psr_op && psr_write && !psr_whole && !psr_saved
		|=> current_status_word_ff == {$past(src[31:28]), $past(current_status_word_ff[27:0])})
		else $error("flags-only write wrong");
	status_read_a: assert property (accept && psr_op && !psr_write && !psr_saved
		|=> reg_write_ff && reg_data_ff == $past(current_status_word_ff))
		else $error("status read wrong");
	test_nowrite_a: assert property (accept && dp_op && is_test |=> !reg_write_ff || $past(psr_op))
		else $error("test op wrote a register");
	pcwr_cycles_a: assert property (accept && pc_wr && !reg_shift
		|=> !issue_ready_ff [*2] ##1 issue_ready_ff)
		else $error("pc write cycle count wrong");
	psr_cycle_a: assert property (accept && psr_op |=> issue_ready_ff)
		else $error("transfer took more than one cycle");
endmodule // pws_core
`default_nettype wire

// >>> design/pws_pkg.sv
// constants, types and decode helpers for the pc write and status transfer block
// assumes one 125 MHz core clock and an instruction already passed its condition check
package pws_pkg;

	// =====================================================================
	// instruction fields
	localparam int PWS_CLASS_LO = 26;
	localparam int PWS_B_IMM = 25;
	localparam int PWS_OP_LO = 21;
	localparam int PWS_B_SETF = 20;
	localparam int PWS_RD_LO = 12;
	localparam int PWS_ROT_LO = 8;
	localparam int PWS_B_MULT = 7;
	localparam int PWS_B_REGSHIFT = 4;
	localparam int PWS_B_PSR_SAVED = 22;
	localparam int PWS_B_PSR_WRITE = 21;
	localparam int PWS_B_PSR_WHOLE = 16;
	localparam logic [1:0] PWS_CLASS_DP = 2'h0;
	localparam logic [3:0] PWS_PC_REG = 4'hf;
	localparam logic [1:0] PWS_OP_TESTS = 2'h2;
	localparam logic [3:0] PWS_OP_CMP = 4'ha;
	localparam logic [3:0] PWS_OP_CMN = 4'hb;

	// =====================================================================
	// status word layout and values
	localparam int PWS_SW_N = 31;
	localparam int PWS_SW_Z = 30;
	localparam int PWS_SW_C = 29;
	localparam int PWS_SW_V = 28;
	localparam logic [31:0] PWS_SW_RESET = 32'h0000_00d3;
	localparam logic [31:0] PWS_SAVED_RESET = 32'h0000_0000;
	localparam logic [4:0] PWS_MODE_USR = 5'h10;
	localparam logic [4:0] PWS_MODE_FIQ = 5'h11;
	localparam logic [4:0] PWS_MODE_IRQ = 5'h12;
	localparam logic [4:0] PWS_MODE_SVC = 5'h13;
	localparam logic [4:0] PWS_MODE_ABT = 5'h17;
	localparam logic [4:0] PWS_MODE_UND = 5'h1b;

	// =====================================================================
	// program counter look-ahead and cycle costs
	localparam logic [31:0] PWS_PC_AHEAD_IMM = 32'h0000_0008;
	localparam logic [31:0] PWS_PC_AHEAD_REG = 32'h0000_000c;
	localparam logic [1:0] PWS_CYC_S_PLAIN = 2'h1;
	localparam logic [1:0] PWS_CYC_S_PCWR = 2'h2;
	localparam logic [1:0] PWS_CYC_N_PCWR = 2'h1;
	localparam logic [1:0] PWS_CYC_I_REGSHIFT = 2'h1;

	// =====================================================================
	// saved word banks
	localparam int PWS_BANKS = 5;
	localparam int PWS_BANK_AW = 3;
	localparam logic [PWS_BANK_AW-1:0] PWS_BANK_NONE = 3'h7;

	typedef enum logic {PWS_ST_IDLE, PWS_ST_BUSY} pws_state_t;

	function automatic logic [PWS_BANK_AW-1:0] pws_bank_of(input logic [4:0] mode);
		case (mode)
			PWS_MODE_FIQ: pws_bank_of = 3'h0;
			PWS_MODE_IRQ: pws_bank_of = 3'h1;
			PWS_MODE_SVC: pws_bank_of = 3'h2;
			PWS_MODE_ABT: pws_bank_of = 3'h3;
			PWS_MODE_UND: pws_bank_of = 3'h4;
			default: pws_bank_of = PWS_BANK_NONE;
		endcase
	endfunction

	function automatic logic pws_is_priv(input logic [4:0] mode);
		pws_is_priv = (mode != PWS_MODE_USR);
	endfunction

	// 8-bit immediate rotated right by twice the rotate field
	function automatic logic [31:0] pws_rot_imm(input logic [7:0] v, input logic [3:0] r);
		logic [63:0] d;
		d = {24'h00_0000, v, 24'h00_0000, v} >> {r, 1'b0};
		pws_rot_imm = d[31:0];
	endfunction

endpackage

// >>> design/pws_saved_bank.sv
// banked saved status words, one per privileged exception mode
// assumes rd_addr names the bank of the mode in force after this edge
`timescale 1ns/100ps
`default_nettype none
module pws_saved_bank (
	input wire logic clk,
	input wire logic rst_b,
	pws_bank_if.mem bif
);
	logic [31:0] mem_ff [pws_pkg::PWS_BANKS];

	// =====================================================================
	// storage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < pws_pkg::PWS_BANKS; i++) begin
				mem_ff[i] <= pws_pkg::PWS_SAVED_RESET;
			end
		end else if (bif.wr_en && (bif.wr_addr < pws_pkg::PWS_BANK_AW'(pws_pkg::PWS_BANKS))) begin
			mem_ff[bif.wr_addr] <= bif.wr_data;
		end
	end

	// =====================================================================
	// registered read, forwarding a same-edge write so no stale word is seen
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bif.rd_data <= pws_pkg::PWS_SAVED_RESET;
		end else if (bif.rd_addr >= pws_pkg::PWS_BANK_AW'(pws_pkg::PWS_BANKS)) begin
			bif.rd_data <= pws_pkg::PWS_SAVED_RESET;
		end else if (bif.wr_en && (bif.wr_addr == bif.rd_addr)) begin
			bif.rd_data <= bif.wr_data;
		end else begin
			bif.rd_data <= mem_ff[bif.rd_addr];
		end
	end
endmodule // pws_saved_bank
`default_nettype wire
